// ---- design/dpw_pkg.sv ----
package dpw_pkg;
    // Upper five address bits; value is arbitrary
    parameter logic [4:0] DPW_ADDR_UPPER = 5'h11;
    localparam logic [6:0] DPW_WIPER_PWRUP = 7'h40;
    localparam logic [7:0] DPW_SEL_NV = 8'h00;
    localparam logic [7:0] DPW_SEL_VOL = 8'h80;
    localparam logic [7:0] DPW_REG_WIPER = 8'h00;
    localparam logic [7:0] DPW_REG_SELECT = 8'h02;
    localparam int DPW_CLK_HZ = 50000000;
    localparam int DPW_NV_CYCLE_MS = 12;
    localparam int DPW_NV_CYCLE_MAX_MS = 20;
    localparam int DPW_NV_CYCLES = DPW_CLK_HZ / 1000 * DPW_NV_CYCLE_MS;
    localparam int DPW_PWRUP_US = 100;
    localparam int DPW_PWRUP_CYCLES = DPW_CLK_HZ / 1000000 * DPW_PWRUP_US;
    localparam int DPW_CNT_W = 24;
    localparam int DPW_RW_BIT = 0;
    localparam logic [3:0] DPW_BIT_ACK = 4'h8;
    localparam logic [3:0] DPW_BIT_LAST = 4'h7;

    typedef enum logic [2:0] {
        DPW_IDLE = 3'b000,
        DPW_ADDR = 3'b001,
        DPW_REGA = 3'b011,
        DPW_WDAT = 3'b010,
        DPW_RDAT = 3'b110,
        DPW_SKIP = 3'b111
    } dpw_state_t;
endpackage

// ---- design/dpw_nv_store.sv ----
`timescale 1ns/1ps
module dpw_nv_store (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [6:0] wr_data,
    output logic [6:0] rd_data
);
    // Nonvolatile 7-bit value; rst_b stands for loss of power, so the held
    // value is kept across it by design of the storage cell model.
    logic [6:0] cell_q = dpw_pkg::DPW_WIPER_PWRUP;

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            cell_q <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= dpw_pkg::DPW_WIPER_PWRUP;
        end else begin
            rd_data <= cell_q;
        end
    end
endmodule

// ---- design/dpw_wiper_slave.sv ----
`timescale 1ns/1ps
module dpw_wiper_slave #(
    parameter int NV_CYCLES = dpw_pkg::DPW_NV_CYCLES,
    parameter int PWRUP_CYCLES = dpw_pkg::DPW_PWRUP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    output logic [6:0] wiper_tap,
    output logic busy
);
    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q, a0_s_q, a1_s_q;
    logic scl_d1_q, sda_d1_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            a0_s_q <= 2'h0;
            a1_s_q <= 2'h0;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            a0_s_q <= {a0_s_q[0], addr_strap_bit0};
            a1_s_q <= {a1_s_q[0], addr_strap_bit1};
            scl_d1_q <= scl_s_q[1];
            sda_d1_q <= sda_s_q[1];
        end
    end

    wire scl_rise = scl_s_q[1] & ~scl_d1_q;
    wire scl_fall = ~scl_s_q[1] & scl_d1_q;
    wire start_det = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1];
    wire stop_det = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1];

    // ------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------
    dpw_pkg::dpw_state_t state_q, state_d;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] reg_ptr_q;
    logic [7:0] select_q;
    logic [6:0] wiper_q;
    logic ack_q;
    logic nv_pend_q;
    logic master_nack_q;
    logic [dpw_pkg::DPW_CNT_W-1:0] timer_q;
    logic prog_q;
    logic pwrup_q;
    logic recall_q;
    logic [6:0] nv_rd;
    logic is_read_q;

    wire [7:0] rx_byte = {shift_q[6:0], sda_s_q[1]};
    wire byte_done = scl_rise && bit_q == dpw_pkg::DPW_BIT_LAST;
    wire ack_slot_rise = scl_rise && bit_q == dpw_pkg::DPW_BIT_ACK;
    wire [6:0] my_addr = {dpw_pkg::DPW_ADDR_UPPER,
                          a1_s_q[1], a0_s_q[1]};
    wire addr_match = rx_byte[7:1] == my_addr;
    wire is_read = rx_byte[dpw_pkg::DPW_RW_BIT];
    wire ptr_wiper = reg_ptr_q == dpw_pkg::DPW_REG_WIPER;
    wire ptr_select = reg_ptr_q == dpw_pkg::DPW_REG_SELECT;
    wire sel_vol = select_q == dpw_pkg::DPW_SEL_VOL;
    wire wr_byte = state_q == dpw_pkg::DPW_WDAT && byte_done;
    wire wr_wiper = wr_byte && ptr_wiper;
    wire nv_write = wr_wiper && !sel_vol;
    wire [7:0] read_val = ptr_select ? select_q :
                          ptr_wiper ? {1'b0, sel_vol ? wiper_q : nv_rd} :
                          8'h00;
    wire start_ok = start_det && !busy;
    wire prog_go = stop_det && nv_pend_q;

    assign busy = prog_q | pwrup_q;
    assign wiper_tap = wiper_q;

    always_comb begin
        state_d = state_q;
        if (start_ok) begin
            state_d = dpw_pkg::DPW_ADDR;
        end else if (stop_det || start_det) begin
            state_d = dpw_pkg::DPW_IDLE;
        end else if (ack_slot_rise) begin
            case (state_q)
                dpw_pkg::DPW_ADDR: begin
                    state_d = !ack_q ? dpw_pkg::DPW_SKIP :
                              is_read_q ? dpw_pkg::DPW_RDAT :
                              dpw_pkg::DPW_REGA;
                end
                dpw_pkg::DPW_REGA: state_d = dpw_pkg::DPW_WDAT;
                dpw_pkg::DPW_RDAT: begin
                    if (sda_s_q[1]) begin
                        state_d = dpw_pkg::DPW_SKIP;
                    end
                end
                default: state_d = state_q;
            endcase
        end
    end

    // Shift counter and receive register, sampled on rising SCL
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= dpw_pkg::DPW_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            is_read_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start_det) begin
                bit_q <= 4'h0;
            end else if (scl_rise) begin
                shift_q <= rx_byte;
                bit_q <= ack_slot_rise ? 4'h0 : bit_q + 4'h1;
            end
            if (byte_done && state_q == dpw_pkg::DPW_ADDR) begin
                is_read_q <= is_read;
            end
        end
    end

    // Acknowledge and transmit, updated on falling SCL
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            tx_q <= 8'hff;
            sda_oe <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            if (byte_done) begin
                case (state_q)
                    dpw_pkg::DPW_ADDR: ack_q <= addr_match;
                    dpw_pkg::DPW_REGA, dpw_pkg::DPW_WDAT: ack_q <= 1'b1;
                    default: ack_q <= 1'b0;
                endcase
            end
            if (scl_fall) begin
                if (bit_q == dpw_pkg::DPW_BIT_ACK) begin
                    sda_oe <= ack_q;
                end else if (state_q == dpw_pkg::DPW_RDAT) begin
                    if (bit_q == 4'h0) begin
                        sda_oe <= ~read_val[7];
                        tx_q <= {read_val[6:0], 1'b1};
                    end else begin
                        sda_oe <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b1};
                    end
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    assign sda_out = 1'b0;

    // Register pointer, selector, wiper
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_ptr_q <= 8'h00;
            select_q <= dpw_pkg::DPW_SEL_NV;
            wiper_q <= dpw_pkg::DPW_WIPER_PWRUP;
            nv_pend_q <= 1'b0;
        end else begin
            if (state_q == dpw_pkg::DPW_REGA && byte_done) begin
                reg_ptr_q <= rx_byte;
            end
            if (wr_byte && ptr_select) begin
                select_q <= rx_byte;
            end
            if (recall_q) begin
                wiper_q <= nv_rd;
            end else if (wr_wiper) begin
                wiper_q <= rx_byte[6:0];
            end
            if (start_ok || prog_go) begin
                nv_pend_q <= 1'b0;
            end else if (nv_write) begin
                nv_pend_q <= 1'b1;
            end
        end
    end

    logic [6:0] nv_data_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_data_q <= 7'h00;
        end else if (nv_write) begin
            nv_data_q <= rx_byte[6:0];
        end
    end

    // ------------------------------------------------------------
    // Power-up recall and programming timer
    // ------------------------------------------------------------
    // Cell is committed at the end of the cycle, as a real array would.
    wire prog_end = prog_q && timer_q == '0;
    wire pwr_end = pwrup_q && timer_q == '0;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrup_q <= 1'b1;
            prog_q <= 1'b0;
            recall_q <= 1'b0;
            timer_q <= dpw_pkg::DPW_CNT_W'(PWRUP_CYCLES - 1);
        end else begin
            recall_q <= pwr_end;
            if (pwr_end) begin
                pwrup_q <= 1'b0;
            end
            if (prog_go && !prog_q) begin
                prog_q <= 1'b1;
                timer_q <= dpw_pkg::DPW_CNT_W'(NV_CYCLES - 1);
            end else if (prog_end) begin
                prog_q <= 1'b0;
            end else if (busy) begin
                timer_q <= timer_q - 1'b1;
            end
        end
    end

    dpw_nv_store u_nv (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(prog_end),
        .wr_data(nv_data_q),
        .rd_data(nv_rd)
    );
endmodule

// ---- tb/dpw_wiper_chk.sv ----
`timescale 1ns/1ps
module dpw_wiper_chk #(
    parameter int NV_CYCLES = 600000
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic [6:0] wiper_tap,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Consecutive busy cycles; bounds power-up and programming alike
    int busy_len_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_len_q <= 0;
        end else begin
            busy_len_q <= busy ? busy_len_q + 1 : 0;
        end
    end
    sequence s_held;
        sda_oe [*4];
    endsequence
    a_od_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_pwrup_state: assert property ($rose(rst_b) |-> busy && wiper_tap == 7'h40)
        else $error("bad state after reset");
    a_busy_noack: assert property (busy |-> !sda_oe)
        else $error("data line pulled while busy");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data output moved with clock high");
    a_wiper_scl: assert property ($changed(wiper_tap) |-> $past(scl_in) || $past(busy) || $past(busy, 2))
        else $error("wiper moved off a clock rise");
    a_busy_stop: assert property ($rose(busy) |-> scl_in && sda_in)
        else $error("programming started without stop");
    a_busy_bound: assert property (busy_len_q <= NV_CYCLES + 8)
        else $error("programming cycle too long");
    a_oe_stands: assert property ($rose(sda_oe) |-> s_held)
        else $error("data output too short");
endmodule

// ---- tb/dpw_i2c_master.sv ----
`timescale 1ns/1ps
module dpw_i2c_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int Q = 40;
    // Clock stands high between frames; data idles via pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #Q sda_low = !b;
        #Q scl = 1'b1;
        #(Q + Q / 2) r = sda;
        #(Q / 2) scl = 1'b0;
    endtask
    // Late rise lets a slave ack drop before a repeated start
    task automatic start();
        sda_low = 1'b0;
        #(2 * Q) scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #(3 * Q);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, ack);
    endtask
endmodule

// ---- tb/dpw_wiper_slave_tb.sv ----
`timescale 1ns/1ps
module dpw_wiper_slave_tb;
    localparam int NV = 200;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] st = 2'b00;
    logic scl;
    logic sda_low;
    logic sda_oe;
    logic sda_out;
    logic [6:0] wiper_tap;
    logic busy;
    wire sda = !((sda_oe && !sda_out) || sda_low);
    int err_total = 0;
    int n_tests = 0;
    always #10 ref_clk = !ref_clk;
    dpw_i2c_master i_dpw_i2c_master (.scl(scl), .sda_low(sda_low), .sda(sda));
    dpw_wiper_slave #(.NV_CYCLES(NV), .PWRUP_CYCLES(20)) i_dpw_wiper_slave (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(st[0]),
        .addr_strap_bit1(st[1]), .wiper_tap(wiper_tap), .busy(busy));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic idle();
        for (int k = 0; k < 400 && busy !== 1'b0; k++) begin
            @(posedge ref_clk);
        end
        #1 chk({7'h0, busy}, 8'h00);
    endtask
    task automatic xa(input logic [7:0] d, input logic nack);
        logic [7:0] q;
        logic a;
        i_dpw_i2c_master.xfer(d, 1'b1, q, a);
        chk({7'h0, a}, {7'h0, nack});
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        i_dpw_i2c_master.start();
        xa({dpw_pkg::DPW_ADDR_UPPER, st, 1'b0}, 1'b0);
        xa(ra, 1'b0);
        xa(d, 1'b0);
        i_dpw_i2c_master.stop();
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        i_dpw_i2c_master.start();
        xa({dpw_pkg::DPW_ADDR_UPPER, st, 1'b0}, 1'b0);
        xa(ra, 1'b0);
        i_dpw_i2c_master.start();
        xa({dpw_pkg::DPW_ADDR_UPPER, st, 1'b1}, 1'b0);
        i_dpw_i2c_master.xfer(8'hff, 1'b1, q, a);
        i_dpw_i2c_master.stop();
        chk(q, exp);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic do_reset(input logic [6:0] exp);
        rst_b = 1'b0;
        repeat (6) @(posedge ref_clk);
        chk({1'b0, wiper_tap}, 8'h40);
        #1 rst_b = 1'b1;
        idle();
        chk({1'b0, wiper_tap}, {1'b0, exp});
    endtask
    task automatic t_addr();
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk);
            #1 st = s[1:0];
            i_dpw_i2c_master.start();
            xa({dpw_pkg::DPW_ADDR_UPPER, ~st, 1'b0}, 1'b1);
            i_dpw_i2c_master.stop();
            i_dpw_i2c_master.start();
            xa({~dpw_pkg::DPW_ADDR_UPPER, st, 1'b0}, 1'b1);
            i_dpw_i2c_master.stop();
            rd(dpw_pkg::DPW_REG_SELECT, 8'h00);
        end
    endtask
    task automatic t_nv_write();
        wr(dpw_pkg::DPW_REG_WIPER, 8'ha5);
        chk({1'b0, wiper_tap}, 8'h25);
        chk({7'h0, busy}, 8'h01);
        i_dpw_i2c_master.start();
        xa({dpw_pkg::DPW_ADDR_UPPER, st, 1'b0}, 1'b1);
        i_dpw_i2c_master.stop();
        idle();
        rd(dpw_pkg::DPW_REG_WIPER, 8'h25);
    endtask
    task automatic t_volatile();
        wr(dpw_pkg::DPW_REG_SELECT, dpw_pkg::DPW_SEL_VOL);
        wr(dpw_pkg::DPW_REG_WIPER, 8'h7f);
        chk({7'h0, busy}, 8'h00);
        chk({1'b0, wiper_tap}, 8'h7f);
        rd(dpw_pkg::DPW_REG_WIPER, 8'h7f);
        wr(dpw_pkg::DPW_REG_SELECT, dpw_pkg::DPW_SEL_NV);
        rd(dpw_pkg::DPW_REG_WIPER, 8'h25);
    endtask
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
    initial begin
        do_reset(7'h40);
        t_addr();
        t_nv_write();
        t_volatile();
        do_reset(7'h25);
        wrap_up();
    end
endmodule
bind dpw_wiper_slave dpw_wiper_chk #(.NV_CYCLES(NV_CYCLES)) i_dpw_wiper_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(addr_strap_bit0),
    .addr_strap_bit1(addr_strap_bit1), .wiper_tap(wiper_tap), .busy(busy));
